// File: pkg/serial_port_pkg.sv
// Purpose: Shared constants for the host serial configuration port.
// Assumes: 16-bit frame: flag, 7 address bits, 8 data bits, MSB first.
// Notes:   Read flag polarity is a plain default.
package serial_port_pkg;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ADDR_BITS  = 7;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned NUM_REGS   = 128;
  localparam logic        READ_FLAG  = 1'b1;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [3:0]  CNT_RESET  = 4'h0;
  localparam logic [3:0]  CNT_ADDR_DONE = 4'h7;
  localparam logic [3:0]  CNT_LAST   = 4'hF;
  localparam logic [1:0]  SYNC_RESET = 2'h3;
endpackage

// File: src/pin_sync.sv
// Purpose: Two-flop synchroniser for one asynchronous pin.
// Assumes: Reset value given by parameter.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;

  // Two register stages toward the system clock.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// File: src/host_serial_config_port.sv
// Purpose: Serial command register port for a host processor, with hardware-mode pin reuse.
// Assumes: Serial clock far slower than sys_clk; all pins synchronised first.
// Notes:   Bit 0 flag, bits 1-7 address, bits 8-15 data, MSB first.
//
// What this block does
// - Read shifts addressed register out serially.
// - Output changes only on serial clock falls.
// - Output tri-stated after read completes.
// - Hardware mode: output pin is monitor strap.
// - Input bits sampled on serial clock rises.
// - Hardware mode: input pin is power strap.
// - Low strap hardware mode, high host mode.
`timescale 1ns/10ps
module host_serial_config_port
  import serial_port_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic host_or_strap_select,
  input  wire logic serial_clk,
  input  wire logic chip_sel_n,
  input  wire logic serial_cmd_in,
  input  wire logic serial_read_out_i,
  output logic      serial_read_out_o,
  output logic      serial_read_out_oe,
  output logic      receive_monitor_strap,
  output logic      receiver_power_strap,
  output logic      host_mode,
  output logic      write_strobe,
  output logic [6:0] write_addr,
  output logic [7:0] write_data
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } phase_t;

  logic       mode_s, clk_s, cs_n_s, sdi_s, mon_s;
  logic       clk_d_r;
  logic       rise, fall;
  phase_t     phase_r;
  logic [3:0] cnt_r;
  logic       is_read_r;
  logic [6:0] addr_r;
  logic [7:0] data_r;
  logic [7:0] shift_r;
  logic [7:0] regs_r [NUM_REGS];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  pin_sync #(.RST_VAL(1'b1)) u_mode (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(host_or_strap_select), .sync_out(mode_s));
  pin_sync #(.RST_VAL(1'b0)) u_clk (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(serial_clk), .sync_out(clk_s));
  pin_sync #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(chip_sel_n), .sync_out(cs_n_s));
  pin_sync #(.RST_VAL(1'b0)) u_sdi (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(serial_cmd_in), .sync_out(sdi_s));
  pin_sync #(.RST_VAL(1'b0)) u_mon (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(serial_read_out_i), .sync_out(mon_s));

  // Mode and strap outputs; straps read pins only in hardware mode.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_mode             <= 1'b1;
      receive_monitor_strap <= 1'b0;
      receiver_power_strap  <= 1'b0;
    end else begin
      host_mode <= mode_s;
      if (!mode_s) begin
        receive_monitor_strap <= mon_s;
        receiver_power_strap  <= sdi_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial clock edge detection on the synchronised copy.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s;
    end
  end

  assign rise = clk_s & ~clk_d_r;
  assign fall = ~clk_s & clk_d_r;

  // Frame sequencing: one bit captured on each of the first sixteen rising edges while selected in host mode.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r   <= ST_IDLE;
      cnt_r     <= CNT_RESET;
      is_read_r <= 1'b0;
      addr_r    <= '0;
      data_r    <= REG_RESET;
    end else if (cs_n_s || !mode_s) begin
      phase_r <= ST_IDLE;
      cnt_r   <= CNT_RESET;
    end else if (rise && phase_r != ST_DONE) begin
      phase_r <= (cnt_r == CNT_LAST) ? ST_DONE : ST_SHIFT;
      cnt_r   <= cnt_r + 4'h1;
      if (cnt_r == CNT_RESET) begin
        is_read_r <= (sdi_s == READ_FLAG);
      end else if (cnt_r <= CNT_ADDR_DONE) begin
        addr_r <= {addr_r[5:0], sdi_s};
      end else begin
        data_r <= {data_r[6:0], sdi_s};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command register array, written when a write frame finishes.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (write_strobe) begin
      regs_r[addr_r] <= {data_r[6:0], sdi_s};
    end
  end

  assign write_strobe = mode_s && !cs_n_s && rise && phase_r == ST_SHIFT
                        && cnt_r == CNT_LAST && !is_read_r;

  // Published copy of the last write.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      write_addr <= '0;
      write_data <= REG_RESET;
    end else if (write_strobe) begin
      write_addr <= addr_r;
      write_data <= {data_r[6:0], sdi_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data: loaded on the falling edge after the last address bit.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r            <= REG_RESET;
      serial_read_out_o  <= 1'b0;
      serial_read_out_oe <= 1'b0;
    end else if (cs_n_s || !mode_s) begin
      serial_read_out_oe <= 1'b0;
    end else if (fall && is_read_r && phase_r == ST_SHIFT) begin
      if (cnt_r == CNT_ADDR_DONE + 4'h1) begin
        shift_r            <= {regs_r[addr_r][6:0], 1'b0};
        serial_read_out_o  <= regs_r[addr_r][7];
        serial_read_out_oe <= 1'b1;
      end else if (cnt_r > CNT_ADDR_DONE + 4'h1) begin
        shift_r           <= {shift_r[6:0], 1'b0};
        serial_read_out_o <= shift_r[7];
      end
    end else if (fall && phase_r == ST_DONE) begin
      serial_read_out_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  a_out_on_fall: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $changed(serial_read_out_o) |-> $past(fall))
    else $error("read output changed off a falling edge");
  a_oe_off_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(cs_n_s) |-> !serial_read_out_oe)
    else $error("read output driven while deselected");
  a_hw_no_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !mode_s |=> !serial_read_out_oe)
    else $error("read output driven in hardware mode");
  a_power_strap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !mode_s |=> receiver_power_strap == $past(sdi_s))
    else $error("power strap not following pin");
  a_mon_strap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !mode_s |=> receive_monitor_strap == $past(mon_s))
    else $error("monitor strap not following pin");
  a_mode_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ##1 host_mode == $past(mode_s))
    else $error("host mode not following strap");
  a_count_on_rise: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cnt_r != $past(cnt_r) && cnt_r != CNT_RESET) |-> $past(rise))
    else $error("bit counted off a rising edge");
  a_write_frame: assert property (@(posedge sys_clk) disable iff (!arst_n)
    write_strobe |=> phase_r == ST_DONE && cnt_r == CNT_RESET)
    else $error("write outside sixteenth bit");
  a_write_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
    write_strobe |=> regs_r[write_addr] == write_data)
    else $error("written byte not stored at its address");
  a_oe_read_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
    serial_read_out_oe |-> is_read_r)
    else $error("read output driven during a write frame");
  a_strap_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_s && $past(mode_s) |-> $stable(receiver_power_strap))
    else $error("power strap moved in host mode");
  a_read_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(serial_read_out_oe) |-> is_read_r && $past(fall))
    else $error("read output enabled without read frame");

  c_write: cover property (@(posedge sys_clk) disable iff (!arst_n) write_strobe);
  c_read: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(serial_read_out_oe));
  c_hw: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(host_mode));
  c_read_start: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(serial_read_out_oe));
  c_host_back: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(host_mode));
endmodule

// File: dv/serial_host_model.sv
// Purpose: Host processor model that runs sixteen-clock serial frames.
// Assumes: Serial clock idles low and stands still between frames.
// Notes:   One serial clock period is sixteen sys_clk periods.
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic sys_clk,
  input  wire logic sdo_pin,
  output logic      serial_clk,
  output logic      chip_sel_n,
  output logic      serial_cmd_in
);
  initial begin
    serial_clk = 1'b0;
    chip_sel_n = 1'b1;
    serial_cmd_in = 1'b0;
  end
  // Waits half a serial clock period, changing nothing off the falling edge.
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask
  // Holds the data line at a level, as a strap would in hardware mode.
  task automatic hold_line(input logic v);
    serial_cmd_in = v;
  endtask
  // Sends flag, address and data MSB first; read bits are taken at rises.
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] word;
    word = {rd, addr, wdata};
    chip_sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_cmd_in = word[i];
      half();
      serial_clk = 1'b1;
      if (i < 8) rdata[i] = sdo_pin;
      half();
      serial_clk = 1'b0;
    end
    half();
    chip_sel_n = 1'b1;
    serial_cmd_in = ~serial_cmd_in;
    half();
  endtask
endmodule

// File: dv/host_serial_config_port_test.sv
// Purpose: Self-checking bench for the host serial configuration port.
// Assumes: Host model drives the serial pins; bench drives straps.
// Notes:   An undriven output pin shows the inverse of the last bit in host mode, and mon_lvl in hardware mode.
`timescale 1ns/10ps
module host_serial_config_port_test;
  import serial_port_pkg::*;
  logic       sys_clk = 1'b0, arst_n = 1'b0, strap_sel = 1'b1, mon_lvl = 1'b0;
  logic       serial_clk, chip_sel_n, serial_cmd_in, sdo_o, sdo_oe, mon_s, pwr_s, host_mode, write_strobe;
  logic [6:0] write_addr;
  logic [7:0] write_data, rd;
  int         n_fail = 0, total_checks = 0, n_strobe = 0;
  wire        sdo_pin = sdo_oe ? sdo_o : (strap_sel ? ~sdo_o : mon_lvl);
  always #2 sys_clk = ~sys_clk;
  host_serial_config_port uut (.sys_clk(sys_clk), .arst_n(arst_n), .host_or_strap_select(strap_sel),
    .serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .serial_cmd_in(serial_cmd_in), .serial_read_out_i(sdo_pin),
    .serial_read_out_o(sdo_o), .serial_read_out_oe(sdo_oe), .receive_monitor_strap(mon_s),
    .receiver_power_strap(pwr_s), .host_mode(host_mode), .write_strobe(write_strobe),
    .write_addr(write_addr), .write_data(write_data));
  serial_host_model host (.sys_clk(sys_clk), .sdo_pin(sdo_pin), .serial_clk(serial_clk),
    .chip_sel_n(chip_sel_n), .serial_cmd_in(serial_cmd_in));
  // Counts write pulses and flags any change of the enabled output while the serial clock is high.
  always @(posedge sys_clk) if (write_strobe === 1'b1) n_strobe++;
  always @(sdo_o) if (sdo_oe === 1'b1 && serial_clk !== 1'b0) check(1'b1, 1'b0);
  // Compares one value and reports a mismatch.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Writes a register and reads it back, then reads an untouched one.
  task automatic write_then_read();
    host.frame(1'b0, 7'h5A, 8'hA5, rd);
    check(n_strobe, 16'h1);
    check({write_addr, write_data}, {7'h5A, 8'hA5});
    host.frame(READ_FLAG, 7'h5A, 8'h00, rd);
    check(rd, 8'hA5);
    check(sdo_oe, 1'b0);
    host.frame(READ_FLAG, 7'h7F, 8'h00, rd);
    check(rd, REG_RESET);
    check(n_strobe, 16'h1);
  endtask
  // Straps hardware mode, checks pin reuse and that frames are ignored.
  task automatic hardware_mode();
    @(negedge sys_clk) strap_sel = 1'b0;
    mon_lvl = 1'b1;
    host.hold_line(1'b1);
    repeat (8) @(negedge sys_clk);
    check(host_mode, 1'b0);
    check(mon_s, 1'b1);
    check(pwr_s, 1'b1);
    host.frame(1'b0, 7'h11, 8'h3C, rd);
    check({write_addr, write_data}, {7'h5A, 8'hA5});
    check(sdo_oe, 1'b0);
    @(negedge sys_clk) strap_sel = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(host_mode, 1'b1);
  endtask
  // Resets in mid-run and reads back a register written earlier.
  task automatic reset_clears();
    @(negedge sys_clk) arst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(sdo_oe, 1'b0);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    host.frame(READ_FLAG, 7'h5A, 8'h00, rd);
    check(rd, REG_RESET);
  endtask
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end
  // Main sequence: reset for four cycles, then the scenarios.
  initial begin
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    write_then_read();
    hardware_mode();
    reset_clears();
    print_verdict();
  end
endmodule
